// [rtl/front_panel_effect_selector.sv]
// Front panel control logic: keys, lamps, effect browsing, load, revert, bypass.
// Assumes keys and MIDI strobe are synchronous to CLK_IN and active high.
`timescale 1ns/10ps
`default_nettype none
`include "fp_defs.svh"

module front_panel_effect_selector #(
    parameter int TICK_CYCLES = `TICK_CYC
) (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [3:0] ADDR_IN,
    input wire logic [31:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [31:0] RDATA_OUT,
    input wire logic KEY_MODE_IN,
    input wire logic KEY_METER_IN,
    input wire logic KEY_GROUP_IN,
    input wire logic KEY_STORE_IN,
    input wire logic KEY_UP_IN,
    input wire logic KEY_DOWN_IN,
    input wire logic KEY_LOAD_IN,
    input wire logic KEY_REVERT_IN,
    input wire logic KEY_PREV_PARAM_IN,
    input wire logic KEY_NEXT_PARAM_IN,
    input wire logic KEY_VALUE_UP_IN,
    input wire logic KEY_VALUE_DOWN_IN,
    input wire logic KEY_COMPARE_IN,
    input wire logic KEY_MAIN_SETTINGS_IN,
    input wire logic KEY_DETAIL_SETTINGS_IN,
    input wire logic KEY_BYPASS_IN,
    input wire logic MIDI_RX_IN,
    input wire logic [1:0] RATE_DETECT_IN,
    output logic SINGLE_CHANNEL_IN_OUT,
    output logic METER_POST_OUT,
    output logic MIDI_LED_OUT,
    output logic [2:0] CLK_SRC_LED_OUT,
    output logic CLOCK_MASTER_OUT,
    output logic [3:0] RATE_LED_OUT,
    output logic INPUT_DIGITAL_OUT,
    output logic [2:0] GROUP_LED_OUT,
    output logic [6:0] EFFECT_NUM_OUT,
    output logic EFFECT_NUM_LIT_OUT,
    output logic [1:0] ACTIVE_GRP_OUT,
    output logic [6:0] ACTIVE_IDX_OUT,
    output logic BYPASS_OUT,
    output logic REVERT_LED_OUT,
    output logic COMPARE_LED_OUT,
    output logic STORE_REFUSED_OUT
);

    // ******************************
    // Millisecond tick
    // ******************************
    logic [16:0] tick_cnt_q;
    logic tick;

    assign tick = (tick_cnt_q == 17'(TICK_CYCLES - 1));

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            tick_cnt_q <= 17'h00000;
        end else if (tick) begin
            tick_cnt_q <= 17'h00000;
        end else begin
            tick_cnt_q <= tick_cnt_q + 17'h00001;
        end
    end

    // ******************************
    // Key debounce and edge detect
    // ******************************
    logic [15:0] raw;
    logic [15:0] key_lvl;
    logic [15:0] key_prev_q;
    logic [15:0] press;
    logic [15:0] ev;
    logic menu;

    assign raw = {KEY_BYPASS_IN, KEY_DETAIL_SETTINGS_IN, KEY_MAIN_SETTINGS_IN,
                  KEY_COMPARE_IN, KEY_VALUE_DOWN_IN, KEY_VALUE_UP_IN,
                  KEY_NEXT_PARAM_IN, KEY_PREV_PARAM_IN, KEY_REVERT_IN, KEY_LOAD_IN,
                  KEY_DOWN_IN, KEY_UP_IN, KEY_STORE_IN, KEY_GROUP_IN,
                  KEY_METER_IN, KEY_MODE_IN};

    for (genvar g = 0; g < 16; g++) begin : g_deb
        logic [9:0] cnt_q;
        logic st_q;
        // A level must hold for the whole debounce time before it is believed
        always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
            if (!RST_N_IN) begin
                cnt_q <= 10'h000;
                st_q <= 1'b0;
            end else if (raw[g] == st_q) begin
                cnt_q <= 10'h000;
            end else if (tick) begin
                if (cnt_q == `DEBOUNCE_MS - 10'h001) begin // see R21
                    st_q <= raw[g];
                    cnt_q <= 10'h000;
                end else begin
                    cnt_q <= cnt_q + 10'h001;
                end
            end
        end
        assign key_lvl[g] = st_q;
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            key_prev_q <= 16'h0000;
        end else begin
            key_prev_q <= key_lvl;
        end
    end

    assign press = key_lvl & ~key_prev_q; // see R21
    assign ev = press & ~(menu ? `MENU_MASK : 16'h0000); // see R13

    // ******************************
    // Control register
    // ******************************
    logic [5:0] ctrl_q;
    fp_pkg::clk_src_e src;
    logic [1:0] rate;
    logic [3:0] rate_led_q;

    assign menu = ctrl_q[`CTRL_MENU_BIT];
    assign src = fp_pkg::clk_src_e'(ctrl_q[`CTRL_SRC_LSB +: 2]);

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            ctrl_q <= `CTRL_RST;
        end else if (WR_IN && ADDR_IN == `CTRL_OFS) begin
            ctrl_q <= WDATA_IN[5:0];
            // The unused source code falls back to the internal clock
            if (WDATA_IN[`CTRL_SRC_LSB +: 2] == 2'h3) begin
                ctrl_q[`CTRL_SRC_LSB +: 2] <= 2'h0;
            end
        end
    end

    // Only the internal oscillator honours the selected rate
    assign rate = (src == fp_pkg::SRC_INTERNAL) ? ctrl_q[`CTRL_RATE_LSB +: 2]
                                                : RATE_DETECT_IN; // see R5

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rate_led_q <= 4'h1;
        end else begin
            rate_led_q <= 4'h1 << rate; // see R5
        end
    end

    assign CLOCK_MASTER_OUT = (src == fp_pkg::SRC_INTERNAL); // see R4
    assign CLK_SRC_LED_OUT = 3'h1 << ctrl_q[`CTRL_SRC_LSB +: 2]; // see R4
    assign RATE_LED_OUT = rate_led_q;
    assign INPUT_DIGITAL_OUT = ctrl_q[`CTRL_DIG_BIT]; // see R6

    // ******************************
    // Input mode and meter source
    // ******************************
    logic single_q;
    logic meter_q;

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            single_q <= 1'b0;
            meter_q <= 1'b0;
        end else begin
            single_q <= single_q ^ ev[`K_MODE]; // see R1
            meter_q <= meter_q ^ ev[`K_METER]; // see R2
        end
    end

    assign SINGLE_CHANNEL_IN_OUT = single_q;
    assign METER_POST_OUT = meter_q;

    // ******************************
    // MIDI activity lamp
    // ******************************
    logic [9:0] midi_cnt_q;

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            midi_cnt_q <= 10'h000;
        end else if (MIDI_RX_IN) begin
            midi_cnt_q <= `MIDI_HOLD_MS; // see R3
        end else if (tick && midi_cnt_q != 10'h000) begin
            midi_cnt_q <= midi_cnt_q - 10'h001;
        end
    end

    assign MIDI_LED_OUT = (midi_cnt_q != 10'h000) || MIDI_RX_IN;

    // ******************************
    // Up and down stepping with repeat
    // ******************************
    logic dir_up_q;
    logic arm_q;
    logic [9:0] rep_cnt_q;
    logic [9:0] rep_thr;
    logic held;
    logic rep_step;
    logic step_up;
    logic step_dn;
    logic up_lvl;
    logic dn_lvl;

    assign up_lvl = key_lvl[`K_UP] && !menu;
    assign dn_lvl = key_lvl[`K_DOWN] && !menu;
    assign held = up_lvl || dn_lvl;
    assign rep_thr = !arm_q ? `REP_DELAY_MS : ((up_lvl && dn_lvl) ? `FAST_MS : `REP_MS);
    assign rep_step = held && tick && (rep_cnt_q == rep_thr - 10'h001);

    // The key held first keeps the direction; the second only speeds it up
    assign step_up = (ev[`K_UP] && !dn_lvl) || (rep_step && dir_up_q); // see R11
    assign step_dn = (ev[`K_DOWN] && !up_lvl) || (rep_step && !dir_up_q); // see R11

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            dir_up_q <= 1'b1;
        end else if (ev[`K_UP] && !dn_lvl) begin
            dir_up_q <= 1'b1;
        end else if (ev[`K_DOWN] && !up_lvl) begin
            dir_up_q <= 1'b0;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rep_cnt_q <= 10'h000;
            arm_q <= 1'b0;
        end else if (!held || (ev[`K_UP] && !dn_lvl) || (ev[`K_DOWN] && !up_lvl)) begin
            rep_cnt_q <= 10'h000;
            arm_q <= 1'b0;
        end else if (rep_step) begin
            rep_cnt_q <= 10'h000;
            arm_q <= 1'b1;
        end else if (tick) begin
            rep_cnt_q <= rep_cnt_q + 10'h001;
        end
    end

    // ******************************
    // Browse, load, revert, store
    // ******************************
    fp_pkg::grp_e bgrp_q;
    fp_pkg::grp_e lgrp_q;
    fp_pkg::grp_e ugrp_q;
    logic [6:0] bidx_q;
    logic [6:0] lidx_q;
    logic [6:0] uidx_q;
    logic [6:0] bsize;
    logic [98:0] occ_q;
    logic undo_q;
    logic ubyp_q;
    logic uedit_q;
    logic bypass_q;
    logic edited_q;
    logic refused_q;
    logic browsing;
    logic load_ok;
    logic revert_ok;
    logic store_ok;
    logic store_bad;

    function automatic logic [6:0] grp_size(input fp_pkg::grp_e g);
        case (g)
            fp_pkg::GRP_FACTORY: grp_size = `FACTORY_SIZE; // see R7
            fp_pkg::GRP_LEGACY: grp_size = `LEGACY_SIZE; // see R8
            default: grp_size = `CUSTOM_SIZE; // see R9
        endcase
    endfunction

    function automatic fp_pkg::grp_e grp_next(input fp_pkg::grp_e g);
        case (g)
            fp_pkg::GRP_FACTORY: grp_next = fp_pkg::GRP_LEGACY;
            fp_pkg::GRP_LEGACY: grp_next = fp_pkg::GRP_CUSTOM;
            default: grp_next = fp_pkg::GRP_FACTORY;
        endcase
    endfunction

    assign bsize = grp_size(bgrp_q);
    assign browsing = (bgrp_q != lgrp_q) || (bidx_q != lidx_q);
    // An empty custom slot holds nothing to load
    assign load_ok = ev[`K_LOAD] && (bgrp_q != fp_pkg::GRP_CUSTOM || occ_q[bidx_q]);
    assign revert_ok = ev[`K_REVERT] && undo_q;
    assign store_ok = ev[`K_STORE] && bgrp_q == fp_pkg::GRP_CUSTOM; // see R9
    assign store_bad = ev[`K_STORE] && bgrp_q != fp_pkg::GRP_CUSTOM; // see R7 R8

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            bgrp_q <= fp_pkg::GRP_FACTORY;
            bidx_q <= 7'h00;
        end else if (revert_ok) begin
            bgrp_q <= ugrp_q;
            bidx_q <= uidx_q;
        end else if ((ev & `CANCEL_MASK) != 16'h0000) begin
            bgrp_q <= lgrp_q; // see R14
            bidx_q <= lidx_q;
        end else if (ev[`K_GROUP]) begin
            bgrp_q <= grp_next(bgrp_q); // see R10
            bidx_q <= 7'h00;
        end else if (step_up) begin
            bidx_q <= (bidx_q == bsize - 7'h01) ? 7'h00 : bidx_q + 7'h01;
        end else if (step_dn) begin
            bidx_q <= (bidx_q == 7'h00) ? bsize - 7'h01 : bidx_q - 7'h01;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            lgrp_q <= fp_pkg::GRP_FACTORY;
            lidx_q <= 7'h00;
            ugrp_q <= fp_pkg::GRP_FACTORY;
            uidx_q <= 7'h00;
            undo_q <= 1'b0;
            ubyp_q <= 1'b0;
            uedit_q <= 1'b0;
        end else if (load_ok) begin
            lgrp_q <= bgrp_q; // see R15 R16
            lidx_q <= bidx_q;
            ugrp_q <= lgrp_q; // see R17
            uidx_q <= lidx_q;
            ubyp_q <= bypass_q;
            uedit_q <= edited_q;
            undo_q <= 1'b1;
        end else if (revert_ok) begin
            lgrp_q <= ugrp_q; // see R17
            lidx_q <= uidx_q;
            undo_q <= 1'b0;
        end else if (store_ok) begin
            lgrp_q <= bgrp_q;
            lidx_q <= bidx_q;
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            occ_q <= '0;
        end else if (store_ok) begin
            occ_q[bidx_q] <= 1'b1; // see R9
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            bypass_q <= 1'b0;
        end else if (load_ok) begin
            bypass_q <= 1'b0; // see R19
        end else if (revert_ok) begin
            bypass_q <= ubyp_q;
        end else if (ev[`K_BYP]) begin
            bypass_q <= !bypass_q; // see R18
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            edited_q <= 1'b0;
        end else if (load_ok || store_ok) begin
            edited_q <= 1'b0; // see R20
        end else if (revert_ok) begin
            edited_q <= uedit_q;
        end else if (ev[`K_VUP] || ev[`K_VDN]) begin
            edited_q <= 1'b1; // see R20
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            refused_q <= 1'b0;
        end else begin
            refused_q <= store_bad; // see R7 R8
        end
    end

    // ******************************
    // Effect number blink
    // ******************************
    logic [9:0] blink_cnt_q;
    logic phase_q;

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            blink_cnt_q <= 10'h000;
            phase_q <= 1'b1;
        end else if (!browsing) begin
            blink_cnt_q <= 10'h000;
            phase_q <= 1'b1;
        end else if (tick) begin
            if (blink_cnt_q == `BLINK_MS - 10'h001) begin
                blink_cnt_q <= 10'h000;
                phase_q <= !phase_q; // see R12
            end else begin
                blink_cnt_q <= blink_cnt_q + 10'h001;
            end
        end
    end

    assign EFFECT_NUM_LIT_OUT = !browsing || phase_q; // see R12 R16
    assign EFFECT_NUM_OUT = bidx_q + 7'h01;
    assign GROUP_LED_OUT = 3'h1 << bgrp_q; // see R10
    assign ACTIVE_GRP_OUT = lgrp_q;
    assign ACTIVE_IDX_OUT = lidx_q;
    assign BYPASS_OUT = bypass_q;
    assign REVERT_LED_OUT = undo_q; // see R17
    assign COMPARE_LED_OUT = edited_q;
    assign STORE_REFUSED_OUT = refused_q;

    // ******************************
    // Register read
    // ******************************
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            RDATA_OUT <= 32'h00000000;
        end else if (RD_IN && ADDR_IN == `CTRL_OFS) begin
            RDATA_OUT <= {26'h0000000, ctrl_q};
        end else if (RD_IN && ADDR_IN == `STAT_OFS) begin
            RDATA_OUT <= {8'h00, lidx_q, lgrp_q, bidx_q, bgrp_q, browsing,
                          edited_q, undo_q, bypass_q, meter_q, single_q};
        end else begin
            RDATA_OUT <= 32'h00000000;
        end
    end

    // ******************************
    // Assertions
    // ******************************
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RST_N_IN);

    a_mode_toggle: assert property (ev[`K_MODE] |=> single_q != $past(single_q)) // see R1
        else $error("input mode did not toggle");
    a_meter_toggle: assert property (ev[`K_METER] |=> meter_q != $past(meter_q)) // see R2
        else $error("meter source did not toggle");
    a_midi_lamp: assert property (MIDI_RX_IN |=> MIDI_LED_OUT [*2]) // see R3
        else $error("midi lamp not held");
    a_clock_slave: assert property ((WR_IN && ADDR_IN == `CTRL_OFS // see R4
        && WDATA_IN[1:0] == 2'h2) |=> !CLOCK_MASTER_OUT && CLK_SRC_LED_OUT == 3'h4)
        else $error("sync jack source not slave");
    a_rate_ext: assert property ((src != fp_pkg::SRC_INTERNAL // see R5
        && RATE_DETECT_IN == 2'h3) |=> RATE_LED_OUT == 4'h8)
        else $error("slave rate not shown");
    a_input_src: assert property ((WR_IN && ADDR_IN == `CTRL_OFS // see R6
        && WDATA_IN[4]) |=> INPUT_DIGITAL_OUT)
        else $error("input source lamp wrong");
    a_store_fact: assert property ((ev[`K_STORE] && bgrp_q == fp_pkg::GRP_FACTORY) // see R7
        |=> STORE_REFUSED_OUT && $stable(occ_q))
        else $error("factory store not refused");
    a_store_leg: assert property ((ev[`K_STORE] && bgrp_q == fp_pkg::GRP_LEGACY) // see R8
        |=> STORE_REFUSED_OUT && $stable(occ_q))
        else $error("legacy store not refused");
    a_store_cust: assert property (store_ok |=> occ_q[$past(bidx_q)] && !browsing) // see R9
        else $error("custom store lost");
    a_group_adv: assert property ((ev == 16'h0004 && bgrp_q == fp_pkg::GRP_LEGACY) // see R10
        |=> bgrp_q == fp_pkg::GRP_CUSTOM && GROUP_LED_OUT == 3'h4)
        else $error("group did not advance");
    a_step_up: assert property ((ev == 16'h0010 && !dn_lvl // see R11
        && bidx_q != bsize - 7'h01) |=> bidx_q == $past(bidx_q) + 7'h01)
        else $error("up key did not step");
    a_menu_lock: assert property ((menu && press[`K_GROUP]) |=> $stable(bgrp_q)) // see R13
        else $error("group key acted in menu");
    a_cancel: assert property ((browsing && ev == 16'h0100) |=> !browsing) // see R14
        else $error("browse not cancelled");
    a_load_apply: assert property (load_ok |=> lidx_q == $past(bidx_q) && !BYPASS_OUT // see R15
        && EFFECT_NUM_LIT_OUT && !COMPARE_LED_OUT)
        else $error("load not applied");
    a_revert: assert property (revert_ok |=> !REVERT_LED_OUT && lidx_q == $past(uidx_q)) // see R17
        else $error("revert not applied");
    a_bypass: assert property (ev == 16'h8000 |=> BYPASS_OUT != $past(bypass_q)) // see R18
        else $error("bypass did not toggle");

endmodule

`default_nettype wire

// [rtl/fp_defs.svh]
// Constants of the front panel effect selector: offsets, fields, reset values, timing.
// Assumes a 125 MHz system clock; included by the top module and the bench.
//
// What this block does
// R1 - Channel configuration key toggles single-channel and two-channel input, lamp shows it.
// R2 - Meter key toggles pre-effect and post-effect metering, lamp shows it.
// R3 - MIDI lamp lights whenever MIDI data arrives.
// R4 - Three clock sources: internal makes master, digital input or sync jack slave.
// R5 - Rate lamp shows one of four rates; selectable only on internal clock.
// R6 - Input source lamp shows analog or digital input.
// R7 - Factory group holds 97 read-only effects; stores into it are refused.
// R8 - Legacy group holds 25 read-only effects; stores into it are refused.
// R9 - Custom group starts empty, stores up to 99, recalled like the others.
// R10 - Group key advances through three groups; group lamp shows selection.
// R11 - Up and down keys step, repeat when held, step faster with both.
// R12 - Effect number blinks while browsed effect differs from loaded one.
// R13 - Setup menu active locks out group, store, up, down, load, revert, compare.
// R14 - Revert, parameter, value, compare and settings keys cancel browsing.
// R15 - Load key makes the browsed effect the active effect.
// R16 - A load turns the effect number from blinking to steady.
// R17 - Revert restores the state before the last load; lamp lit while possible.
// R18 - Effect-off key toggles bypass; bypass passes input unmodified.
// R19 - Loading an effect always clears bypass.
// R20 - Compare lamp lights on an edit after load, dark on store or load.
// R21 - Keys are debounced and edge detected: one press, one event.
`ifndef FP_DEFS_SVH
`define FP_DEFS_SVH

// ******************************
// Timing
// ******************************
`define CLK_PERIOD_NS 8
`define TICK_NS 1000000
`define TICK_CYC (`TICK_NS / `CLK_PERIOD_NS)
`define DEBOUNCE_MS 10'h00A
`define REP_DELAY_MS 10'h1F4
`define REP_MS 10'h064
`define FAST_MS 10'h019
`define BLINK_MS 10'h0FA
`define MIDI_HOLD_MS 10'h032

// ******************************
// Group sizes
// ******************************
`define FACTORY_SIZE 7'h61
`define LEGACY_SIZE 7'h19
`define CUSTOM_SIZE 7'h63

// ******************************
// Registers
// ******************************
`define CTRL_OFS 4'h0
`define STAT_OFS 4'h4
`define CTRL_RST 6'h00
`define CTRL_SRC_LSB 0
`define CTRL_RATE_LSB 2
`define CTRL_DIG_BIT 4
`define CTRL_MENU_BIT 5

// ******************************
// Key positions in the key vector
// ******************************
`define K_MODE 0
`define K_METER 1
`define K_GROUP 2
`define K_STORE 3
`define K_UP 4
`define K_DOWN 5
`define K_LOAD 6
`define K_REVERT 7
`define K_VUP 10
`define K_VDN 11
`define K_BYP 15
`define MENU_MASK 16'h10FC
`define CANCEL_MASK 16'h7F80

`endif

// [rtl/fp_pkg.sv]
// Types of the front panel effect selector.
// Assumes nothing of its surroundings.
package fp_pkg;

    typedef enum logic [1:0] {
        GRP_FACTORY,
        GRP_LEGACY,
        GRP_CUSTOM
    } grp_e;

    typedef enum logic [1:0] {
        SRC_INTERNAL,
        SRC_DIGITAL_IN,
        SRC_EXT_SYNC
    } clk_src_e;

endpackage

// [verification/fp_operator.sv]
// Operator at the front panel: presses and lets go of keys.
// Assumes the bench calls press and keys share the block clock.
`timescale 1ns/10ps
`default_nettype none
module fp_operator #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic clk_in,
    output logic [15:0] keys_out
);
    initial keys_out = 16'h0000;
    // Held past debounce, short of auto-repeat, so one press is one step
    task automatic press(input int idx);
        @(posedge clk_in);
        keys_out[idx] <= 1'b1;
        repeat (16 * TICK_CYCLES) @(posedge clk_in);
        keys_out[idx] <= 1'b0;
        repeat (16 * TICK_CYCLES) @(posedge clk_in);
        #1;
    endtask
endmodule
`default_nettype wire

// [verification/tb_top.sv]
// Bench: keys, MIDI strobe and register port of the panel block.
// Assumes the tick is cut to 4 clocks.
`timescale 1ns/10ps
`default_nettype none
`include "fp_defs.svh"
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0;
    logic wstb = 1'b0;
    logic rstb = 1'b0;
    logic midi = 1'b0;
    logic [1:0] rate = 2'h3;
    logic [15:0] k;
    logic [31:0] rdata, d;
    logic single, post, mled, master, digi, lit, byp, rled, cled, refd, dk;
    logic [2:0] sled, gled;
    logic [3:0] rtled;
    logic [6:0] num, aidx;
    logic [1:0] agrp;
    int err_count = 0;
    int n_compared = 0;
    int ref_cnt = 0;
    always #4 clk = ~clk;
    always @(posedge clk) if (refd === 1'b1) ref_cnt++;
    fp_operator #(.TICK_CYCLES(4)) op (.clk_in(clk), .keys_out(k));
    front_panel_effect_selector #(.TICK_CYCLES(4)) uut (
        .CLK_IN(clk), .RST_N_IN(rst_n), .ADDR_IN(addr), .WDATA_IN(wdata),
        .WR_IN(wstb), .RD_IN(rstb), .RDATA_OUT(rdata),
        .KEY_MODE_IN(k[0]), .KEY_METER_IN(k[1]), .KEY_GROUP_IN(k[2]),
        .KEY_STORE_IN(k[3]), .KEY_UP_IN(k[4]), .KEY_DOWN_IN(k[5]),
        .KEY_LOAD_IN(k[6]), .KEY_REVERT_IN(k[7]), .KEY_PREV_PARAM_IN(k[8]),
        .KEY_NEXT_PARAM_IN(k[9]), .KEY_VALUE_UP_IN(k[10]), .KEY_VALUE_DOWN_IN(k[11]),
        .KEY_COMPARE_IN(k[12]), .KEY_MAIN_SETTINGS_IN(k[13]),
        .KEY_DETAIL_SETTINGS_IN(k[14]), .KEY_BYPASS_IN(k[15]),
        .MIDI_RX_IN(midi), .RATE_DETECT_IN(rate), .SINGLE_CHANNEL_IN_OUT(single),
        .METER_POST_OUT(post), .MIDI_LED_OUT(mled), .CLK_SRC_LED_OUT(sled),
        .CLOCK_MASTER_OUT(master), .RATE_LED_OUT(rtled), .INPUT_DIGITAL_OUT(digi),
        .GROUP_LED_OUT(gled), .EFFECT_NUM_OUT(num), .EFFECT_NUM_LIT_OUT(lit),
        .ACTIVE_GRP_OUT(agrp), .ACTIVE_IDX_OUT(aidx), .BYPASS_OUT(byp),
        .REVERT_LED_OUT(rled), .COMPARE_LED_OUT(cled), .STORE_REFUSED_OUT(refd)
    );
    // ********
    // Tasks
    // ********
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            err_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clk);
        addr <= a;
        wdata <= v;
        wstb <= 1'b1;
        @(posedge clk);
        wstb <= 1'b0;
        #1;
    endtask
    task automatic reg_rd(input logic [3:0] a);
        @(posedge clk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic note(input string s);
        $display("test %s done", s);
    endtask
    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // ********
    // Tests
    // ********
    initial begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        #1 chk(32'({single, master, sled, rtled, gled, num, lit}), 32'h48903);
        op.press(`K_MODE);
        chk(32'(single), 32'h1);
        op.press(`K_MODE);
        chk(32'(single), 32'h0);
        op.press(`K_METER);
        chk(32'(post), 32'h1);
        @(posedge clk);
        midi <= 1'b1;
        @(posedge clk);
        midi <= 1'b0;
        #1 chk(32'(mled), 32'h1);
        note("panel");
        reg_wr(`CTRL_OFS, 32'h1);
        repeat (2) @(posedge clk);
        #1 chk(32'({sled, master, rtled}), 32'h48);
        reg_wr(`CTRL_OFS, 32'h2);
        #1 chk(32'(sled), 32'h4);
        reg_wr(`CTRL_OFS, 32'h1C);
        repeat (2) @(posedge clk);
        #1 chk(32'({sled, master, rtled, digi}), 32'h71);
        reg_rd(`CTRL_OFS);
        chk(d, 32'h1C);
        reg_rd(4'h8);
        chk(d, 32'h0);
        note("clock");
        op.press(`K_BYP);
        chk(32'(byp), 32'h1);
        op.press(`K_DOWN);
        reg_rd(`STAT_OFS);
        chk(32'({num, d[5]}), 32'hC3);
        dk = 1'b0;
        repeat (1100) @(posedge clk) if (lit === 1'b0) dk = 1'b1;
        chk(32'(dk), 32'h1);
        op.press(`K_LOAD);
        chk(32'({aidx, byp, rled, lit}), 32'h303);
        op.press(`K_VUP);
        chk(32'(cled), 32'h1);
        op.press(`K_REVERT);
        chk(32'({aidx, byp, rled, cled, num}), 32'h201);
        op.press(`K_UP);
        op.press(8);
        reg_rd(`STAT_OFS);
        chk(32'({num, d[5]}), 32'h2);
        note("browse");
        op.press(`K_STORE);
        chk(32'(ref_cnt), 32'h1);
        op.press(`K_GROUP);
        op.press(`K_STORE);
        chk(32'({gled, 4'(ref_cnt)}), 32'h22);
        op.press(`K_GROUP);
        op.press(`K_UP);
        op.press(`K_LOAD);
        chk(32'({agrp, aidx}), 32'h0);
        op.press(`K_STORE);
        chk(32'({agrp, aidx, 4'(ref_cnt)}), 32'h1012);
        note("groups");
        reg_wr(`CTRL_OFS, 32'h20);
        op.press(`K_GROUP);
        op.press(`K_UP);
        chk(32'({gled, num}), 32'h202);
        reg_wr(`CTRL_OFS, 32'h0);
        op.press(`K_GROUP);
        chk(32'(gled), 32'h1);
        note("menu");
        test_done();
    end
    initial begin
        repeat (40000) @(posedge clk);
        err_count++;
        test_done();
    end
endmodule
`default_nettype wire
